// File: msc_ctrl.sv
// Matrix enable, display source, fade lighting and pattern copy registers
//
// Function
// - Bit D0 switches matrix on, default off
// - Changes while enabled shown in arrival order
// - Source codes up to D0h pick fixed patterns
// - Codes D1h and D2h pick buffer one, two
// - Fixed pattern zero is all dark
// - Fade codes for fixed patterns: direct, 1 s, 2 s, 3 s; buffer sources D1h, D2h always direct
// - Copy source names fixed pattern 0 to 208
// - Copy source refused while copy runs
// - Copy target bit D1 picks destination buffer
// - Trigger starts copy, self-clears after 51 cycles
// - Copy never turns display on
// - Copy into shown buffer updates the image
// - Source, scroll, repeat writes ignored during copy
// - Copy target bit refused while copy runs
// - Busy flag D3 during copy or clear
// - No host buffer access while busy
`timescale 1ns/1ps
module msc_ctrl
    import msc_pkg::*;
#(
    parameter int FADE_1S_CYCLES = FADE_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input msc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Host buffer write port
    input msc_ram_wr_t host_ram_wr,
    output logic host_ram_refused,
    // Buffer clear status from the clear logic
    input wire logic ram_clear_active,
    // Fixed pattern store
    output logic [13:0] rom_addr,
    input wire logic [7:0] rom_data,
    // Display scan
    input wire logic [5:0] scan_idx,
    output logic [7:0] pix_data,
    output msc_disp_t disp,
    // Sequencer register writes
    output logic scroll_wr,
    output logic repeat_wr,
    output logic [7:0] seq_wdata,
    // Misc
    output logic irq_level_select,
    output logic buffer_busy_flag
);
    if (FADE_1S_CYCLES < FADE_LEVELS) begin : g_chk
        $error("msc_ctrl: FADE_1S_CYCLES too small for the fade ramp");
    end

    default clocking cb_chk @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    localparam int STEP_1S = FADE_1S_CYCLES / FADE_LEVELS;

    typedef enum logic [1:0] {
        MSC_IDLE,
        MSC_RAMP,
        MSC_FULL
    } msc_fade_t;

    logic matrix_enable;
    logic [7:0] display_source_select;
    logic [1:0] fade_lighting_select;
    logic [7:0] copy_source_pattern;
    logic copy_target_buffer;
    logic [7:0] test_b, test_c, test_d, test_e;
    logic copy_active;
    logic copy_start;
    logic [5:0] copy_idx;
    msc_ram_wr_t copy_wr;
    msc_ram_wr_t mem_wr;
    logic [7:0] mem_rdata;
    logic busy;
    logic wr_ok;
    logic [7:0] next_rdata;
    logic restart_fade;
    msc_fade_t fade_state;
    logic [31:0] fade_cnt;
    logic [31:0] step_len;
    logic [7:0] level;
    logic use_ram;
    logic ram_sel;
    logic use_ram_q;

    assign busy = copy_active || ram_clear_active;
    // Register writes to copy fields and sources are dropped while a copy runs
    assign wr_ok = reg_req.wr && !copy_active;
    assign copy_start = reg_req.wr && reg_req.addr == ADDR_COPY_CTRL
        && reg_req.wdata[BIT_COPY_TRIG] && !copy_active;
    assign use_ram = display_source_select == SRC_RAM1
        || display_source_select == SRC_RAM2;
    assign ram_sel = display_source_select == SRC_RAM2;

    // Control registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            matrix_enable <= 1'b0;
            fade_lighting_select <= 2'h0;
            irq_level_select <= 1'b0;
            test_b <= REG_RESET;
            test_c <= REG_RESET;
            test_d <= REG_RESET;
            test_e <= REG_RESET;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_MTX_EN:
                    matrix_enable <= reg_req.wdata[BIT_MTX_EN];
                ADDR_FADE: fade_lighting_select <= reg_req.wdata[1:0];
                ADDR_IRQ_CFG: irq_level_select <= reg_req.wdata[BIT_IRQ_LVL];
                ADDR_TEST_B: test_b <= reg_req.wdata;
                ADDR_TEST_C: test_c <= reg_req.wdata;
                ADDR_TEST_D: test_d <= reg_req.wdata;
                ADDR_TEST_E: test_e <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // Fields locked while a copy runs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            display_source_select <= REG_RESET;
            copy_source_pattern <= REG_RESET;
            copy_target_buffer <= 1'b0;
        end else if (wr_ok) begin
            case (reg_req.addr)
                ADDR_DISP_SRC: display_source_select <= reg_req.wdata;
                ADDR_COPY_SRC: copy_source_pattern <= reg_req.wdata;
                ADDR_COPY_CTRL:
                    copy_target_buffer <= reg_req.wdata[BIT_COPY_TGT];
                default: ;
            endcase
        end
    end

    // Scroll and repeat writes are passed on only outside a copy
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scroll_wr <= 1'b0;
            repeat_wr <= 1'b0;
            seq_wdata <= REG_RESET;
        end else begin
            scroll_wr <= wr_ok && reg_req.addr == ADDR_SCROLL;
            repeat_wr <= wr_ok && reg_req.addr == ADDR_REPEAT;
            if (wr_ok) begin
                seq_wdata <= reg_req.wdata;
            end
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        case (reg_req.addr)
            ADDR_STATUS: next_rdata[BIT_BUSY] = busy;
            ADDR_IRQ_CFG: next_rdata[BIT_IRQ_LVL] = irq_level_select;
            ADDR_TEST_B: next_rdata = test_b;
            ADDR_TEST_C: next_rdata = test_c;
            ADDR_TEST_D: next_rdata = test_d;
            ADDR_TEST_E: next_rdata = test_e;
            ADDR_MTX_EN: next_rdata[BIT_MTX_EN] = matrix_enable;
            ADDR_DISP_SRC: next_rdata = display_source_select;
            ADDR_FADE: next_rdata[1:0] = fade_lighting_select;
            ADDR_COPY_SRC:
                next_rdata = copy_active ? 8'h00 : copy_source_pattern;
            ADDR_COPY_CTRL: begin
                next_rdata[BIT_COPY_TGT] =
                    copy_active ? 1'b0 : copy_target_buffer;
                next_rdata[BIT_COPY_TRIG] = copy_active;
            end
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            buffer_busy_flag <= 1'b0;
        end else begin
            buffer_busy_flag <= busy;
        end
    end

    msc_copy_engine #(
        .CYCLES(COPY_CYCLES),
        .CELLS(PATTERN_CELLS)
    ) u_copy (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(copy_start),
        .target(reg_req.wdata[BIT_COPY_TGT]),
        .active(copy_active),
        .rom_idx(copy_idx),
        .rom_data(rom_data),
        .ram_wr(copy_wr)
    );

    // Copy owns the buffer write port; host writes are dropped during busy time
    always_comb begin
        mem_wr = copy_wr;
        if (!copy_active) begin
            mem_wr = host_ram_wr;
            mem_wr.wr = host_ram_wr.wr && !busy;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            host_ram_refused <= 1'b0;
        end else begin
            host_ram_refused <= host_ram_wr.wr && busy;
        end
    end

    msc_pattern_mem #(
        .DEPTH(PATTERN_CELLS),
        .WIDTH(8)
    ) u_mem (
        .ref_clk(ref_clk),
        .wr(mem_wr),
        .rd_sel(ram_sel),
        .rd_idx(scan_idx),
        .rd_data(mem_rdata)
    );

    // Pattern store address: the copy has it, else the display scan
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rom_addr <= 14'h0000;
        end else if (copy_start || copy_active) begin
            // One cycle behind the engine index: it takes data a cycle late
            rom_addr <= {copy_source_pattern,
                copy_start ? 6'h00 : copy_idx};
        end else begin
            rom_addr <= {display_source_select, scan_idx};
        end
    end

    // Buffer reads lag one cycle, so the source choice is delayed to match
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            use_ram_q <= 1'b0;
        end else begin
            use_ram_q <= use_ram;
        end
    end

    // Live buffer read: a copy into the shown buffer appears at once
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pix_data <= 8'h00;
        end else if (!matrix_enable) begin
            pix_data <= 8'h00;
        end else if (use_ram_q) begin
            pix_data <= mem_rdata;
        end else if (display_source_select == SRC_ROM_FIRST) begin
            pix_data <= 8'h00;
        end else if (!copy_active && display_source_select <= SRC_ROM_LAST) begin
            pix_data <= rom_data;
        end
    end

    // Fade ramp restarts on a write to source, fade or matrix enable made outside a copy
    assign restart_fade = wr_ok && (reg_req.addr == ADDR_DISP_SRC
        || reg_req.addr == ADDR_FADE || reg_req.addr == ADDR_MTX_EN);
    assign step_len = 32'(STEP_1S) * {30'h0, fade_lighting_select};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fade_state <= MSC_IDLE;
            fade_cnt <= 32'h0;
            level <= 8'h00;
        end else if (restart_fade || !matrix_enable) begin
            fade_state <= MSC_IDLE;
            fade_cnt <= 32'h0;
            level <= 8'h00;
        end else begin
            case (fade_state)
                MSC_IDLE: begin
                    if (use_ram || fade_lighting_select == FADE_OFF) begin
                        fade_state <= MSC_FULL;
                        level <= 8'hFF;
                    end else begin
                        fade_state <= MSC_RAMP;
                        fade_cnt <= 32'h0;
                    end
                end
                MSC_RAMP: begin
                    if (fade_cnt >= step_len - 32'h1) begin
                        fade_cnt <= 32'h0;
                        level <= level + 8'h01;
                        if (level == 8'hFE) begin
                            fade_state <= MSC_FULL;
                        end
                    end else begin
                        fade_cnt <= fade_cnt + 32'h1;
                    end
                end
                MSC_FULL: level <= 8'hFF;
                default: fade_state <= MSC_IDLE;
            endcase
        end
    end

    // Display view, refreshed every cycle in order of register changes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            disp <= '0;
        end else begin
            disp.enable <= matrix_enable;
            disp.source <= display_source_select;
            disp.use_ram <= use_ram;
            disp.ram_sel <= ram_sel;
            disp.rom_timed <= display_source_select > SRC_ROM_LUM_LAST;
            disp.fade <= fade_lighting_select;
            disp.level <= level;
        end
    end

    // Checks
    logic [5:0] chk_len;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chk_len <= 6'h00;
        end else if (copy_active) begin
            chk_len <= chk_len + 6'h01;
        end else begin
            chk_len <= 6'h00;
        end
    end

    chk_copy_length: assert property (
        $fell(copy_active) |-> $past(chk_len) == 6'(COPY_CYCLES - 1))
        else $error("copy did not last the fixed cycle count");
    chk_copy_start: assert property (
        copy_start |=> copy_active [*8])
        else $error("copy trigger did not start a copy");
    chk_trig_read: assert property (
        reg_req.rd && reg_req.addr == ADDR_COPY_CTRL
        |=> reg_rdata[BIT_COPY_TRIG] == $past(copy_active))
        else $error("trigger readback differs from copy state");
    chk_src_locked: assert property (
        copy_active |=> $stable(display_source_select))
        else $error("source select changed during copy");
    chk_tgt_locked: assert property (
        copy_active |=> $stable(copy_target_buffer)
        && $stable(copy_source_pattern))
        else $error("copy fields changed during copy");
    chk_seq_blocked: assert property (
        copy_active && reg_req.wr |=> !scroll_wr && !repeat_wr)
        else $error("sequencer write passed during copy");
    chk_busy_flag: assert property (
        ##1 buffer_busy_flag == $past(copy_active || ram_clear_active))
        else $error("busy flag does not follow copy or clear");
    chk_host_block: assert property (
        busy && !copy_active |-> !mem_wr.wr)
        else $error("host buffer write while busy");
    chk_copy_no_on: assert property (
        copy_start && !matrix_enable |=> !matrix_enable)
        else $error("copy switched the matrix on");
    chk_dark_off: assert property (
        !matrix_enable |=> pix_data == 8'h00)
        else $error("pixels lit with matrix disabled");
    chk_zero_dark: assert property (
        matrix_enable && display_source_select == SRC_ROM_FIRST
        && !use_ram_q |=> pix_data == 8'h00)
        else $error("pattern zero not dark");

    cov_copy_ram2: cover property (@(posedge ref_clk) disable iff (!nrst)
        copy_start && reg_req.wdata[BIT_COPY_TGT]);
    cov_copy_shown: cover property (@(posedge ref_clk) disable iff (!nrst)
        copy_wr.wr && use_ram && copy_wr.sel == ram_sel);
    cov_fade_full: cover property (@(posedge ref_clk) disable iff (!nrst)
        fade_state == MSC_RAMP ##1 fade_state == MSC_FULL);
    cov_refused: cover property (@(posedge ref_clk) disable iff (!nrst)
        host_ram_refused);
endmodule

// File: msc_pkg.sv
// Shared constants and carrier types of the matrix source and copy control
package msc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_TEST_A = 8'h15;
    localparam logic [7:0] ADDR_TEST_B = 8'h16;
    localparam logic [7:0] ADDR_TEST_C = 8'h17;
    localparam logic [7:0] ADDR_TEST_D = 8'h18;
    localparam logic [7:0] ADDR_TEST_E = 8'h19;
    localparam logic [7:0] ADDR_IRQ_CFG = 8'h1A;
    localparam logic [7:0] ADDR_MTX_EN = 8'h20;
    localparam logic [7:0] ADDR_DISP_SRC = 8'h21;
    localparam logic [7:0] ADDR_FADE = 8'h22;
    localparam logic [7:0] ADDR_COPY_SRC = 8'h23;
    localparam logic [7:0] ADDR_COPY_CTRL = 8'h24;
    localparam logic [7:0] ADDR_REPEAT = 8'h27;
    localparam logic [7:0] ADDR_SCROLL = 8'h2A;

    // Field positions
    localparam int BIT_MTX_EN = 0;
    localparam int BIT_COPY_TRIG = 0;
    localparam int BIT_COPY_TGT = 1;
    localparam int BIT_BUSY = 3;
    localparam int BIT_IRQ_LVL = 7;

    // Reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Source select codes and the fade off code
    localparam logic [7:0] SRC_ROM_FIRST = 8'h00;
    localparam logic [7:0] SRC_ROM_LUM_LAST = 8'h95;
    localparam logic [7:0] SRC_ROM_LAST = 8'hD0;
    localparam logic [7:0] SRC_RAM1 = 8'hD1;
    localparam logic [7:0] SRC_RAM2 = 8'hD2;
    localparam logic [1:0] FADE_OFF = 2'h0;

    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int COPY_CYCLES = 51;
    localparam int PATTERN_CELLS = 49;
    localparam int FADE_UNIT_S = 1;
    localparam int FADE_UNIT_CYCLES = CLK_HZ * FADE_UNIT_S;
    localparam int FADE_LEVELS = 256;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msc_reg_req_t;

    typedef struct packed {
        logic wr;
        logic sel;
        logic [5:0] idx;
        logic [7:0] data;
    } msc_ram_wr_t;

    typedef struct packed {
        logic enable;
        logic [7:0] source;
        logic use_ram;
        logic ram_sel;
        logic rom_timed;
        logic [1:0] fade;
        logic [7:0] level;
    } msc_disp_t;

endpackage

// File: msc_pattern_mem.sv
// Two pattern buffers with one write port and one registered read port
`timescale 1ns/1ps
module msc_pattern_mem
    import msc_pkg::*;
#(
    parameter int DEPTH = PATTERN_CELLS,
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic ref_clk,
    // Write port
    input msc_ram_wr_t wr,
    // Read port
    input wire logic rd_sel,
    input wire logic [5:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    // The index compare is six bits wide, so 64 cells would wrap to zero
    if (DEPTH < 1 || DEPTH > 63 || WIDTH != 8) begin : g_chk
        $error("msc_pattern_mem: unsupported DEPTH or WIDTH");
    end

    logic [WIDTH-1:0] mem [2*DEPTH];
    logic [6:0] wr_addr;
    logic [6:0] rd_addr;

    assign wr_addr = wr.sel ? 7'(DEPTH) + 7'(wr.idx) : 7'(wr.idx);
    assign rd_addr = rd_sel ? 7'(DEPTH) + 7'(rd_idx) : 7'(rd_idx);

    // No reset on the array: buffers are cleared by their own clear logic
    always_ff @(posedge ref_clk) begin
        if (wr.wr && wr.idx < 6'(DEPTH)) begin
            mem[wr_addr] <= wr.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_data <= (rd_idx < 6'(DEPTH)) ? mem[rd_addr] : '0;
    end
endmodule

// File: msc_copy_engine.sv
// Fixed-pattern to buffer copy sequencer, fixed length in cycles
`timescale 1ns/1ps
module msc_copy_engine
    import msc_pkg::*;
#(
    parameter int CYCLES = COPY_CYCLES,
    parameter int CELLS = PATTERN_CELLS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic target,
    output logic active,
    // Pattern store side, data valid in the cycle after the index
    output logic [5:0] rom_idx,
    input wire logic [7:0] rom_data,
    // Buffer write
    output msc_ram_wr_t ram_wr
);
    if (CELLS + 1 > CYCLES || CYCLES > 63 || CELLS > 63) begin : g_chk
        $error("msc_copy_engine: CYCLES must cover CELLS plus one");
    end

    logic [5:0] cnt;
    logic tgt;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            active <= 1'b0;
            cnt <= 6'h00;
        end else if (start && !active) begin
            active <= 1'b1;
            cnt <= 6'h00;
        end else if (active) begin
            cnt <= cnt + 6'h01;
            if (cnt == 6'(CYCLES - 1)) begin
                active <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tgt <= 1'b0;
        end else if (start && !active) begin
            tgt <= target;
        end
    end

    assign rom_idx = cnt;
    always_comb begin
        ram_wr.wr = active && cnt >= 6'h01 && cnt <= 6'(CELLS);
        ram_wr.sel = tgt;
        ram_wr.idx = cnt - 6'h01;
        ram_wr.data = rom_data;
    end
endmodule

// File: msc_rom_model.sv
// Fixed pattern store model seen by the control block
`timescale 1ns/1ps
module msc_rom_model (
    // Pattern store port
    input wire logic [13:0] rom_addr,
    output logic [7:0] rom_data
);
    // No pattern reads as zero here, so a dark pattern zero must come
    // from the block itself and not from a kind store
    assign rom_data = rom_addr[13:6] ^ {rom_addr[5:0], 2'h3} ^ 8'h3C;
endmodule

// File: tb_top.sv
// Self-checking bench of the matrix source and copy control registers
`timescale 1ns/1ps
module tb_top;
    import msc_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    msc_reg_req_t reg_req = '0;
    msc_ram_wr_t host_ram_wr = '0;
    logic ram_clear_active = 1'b0;
    logic [5:0] scan_idx = 6'h00;
    logic [7:0] reg_rdata, rom_data, pix_data, seq_wdata;
    logic [7:0] lfsr = 8'h25;
    logic [13:0] rom_addr;
    logic reg_rvalid, host_ram_refused, scroll_wr, repeat_wr, irq_lvl, busy;
    logic seen_ref = 1'b0, seen_rep = 1'b0, seen_scl = 1'b0;
    msc_disp_t disp;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;

    msc_ctrl #(.FADE_1S_CYCLES(512)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .host_ram_wr(host_ram_wr), .host_ram_refused(host_ram_refused),
        .ram_clear_active(ram_clear_active), .rom_addr(rom_addr),
        .rom_data(rom_data), .scan_idx(scan_idx), .pix_data(pix_data),
        .disp(disp), .scroll_wr(scroll_wr), .repeat_wr(repeat_wr),
        .seq_wdata(seq_wdata), .irq_level_select(irq_lvl),
        .buffer_busy_flag(busy));
    msc_rom_model i_rom (.rom_addr(rom_addr), .rom_data(rom_data));

    always #5 ref_clk = ~ref_clk;
    // Sticky flags catch one-cycle pulses without racing the edge
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (host_ram_refused === 1'b1) seen_ref <= 1'b1;
        if (repeat_wr === 1'b1) seen_rep <= 1'b1;
        if (scroll_wr === 1'b1) seen_scl <= 1'b1;
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    function automatic logic [7:0] rom_at(logic [7:0] p, logic [5:0] k);
        return p ^ {k, 2'h3} ^ 8'h3C;
    endfunction
    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        tick();
        reg_req.wr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        tick();
        reg_req.rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 3) begin
            tick();
            n++;
        end
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
        tick();
    endtask
    task automatic host_wr(input logic [5:0] k, input logic [7:0] d);
        seen_ref = 1'b0;
        host_ram_wr = '{wr: 1'b1, sel: 1'b0, idx: k, data: d};
        tick();
        host_ram_wr.wr = 1'b0;
        tick(2);
    endtask
    task automatic pix(input logic [5:0] k, input logic [7:0] exp);
        scan_idx = k;
        tick(2);
        chk(pix_data, exp);
    endtask
    task automatic complete_run();
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #500000;
        err_count++;
        complete_run();
    end

    initial begin
        logic [7:0] v, p;
        int base;
        logic [7:0] rst_tab [12] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
            8'h19, 8'h1A, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
        logic [7:0] rw_tab [7] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h21,
            8'h23, 8'h1A};
        logic [7:0] src_tab [5] = '{8'h00, 8'h01, 8'h95, 8'h96, 8'hD0};
        tick(2);
        nrst = 1'b1;
        tick();
        foreach (rst_tab[i]) rd(rst_tab[i], 8'h00);
        foreach (rw_tab[i]) begin
            v = rnd();
            wr(rw_tab[i], v);
            rd(rw_tab[i], (rw_tab[i] == 8'h1A) ? (v & 8'h80) : v);
        end
        chk({7'h00, irq_lvl}, {7'h00, v[7]});
        wr(8'h15, rnd());
        rd(8'h15, 8'h00);
        wr(8'h30, rnd());
        rd(8'h30, 8'h00);
        wr(ADDR_MTX_EN, 8'h01);
        chk({7'h00, disp.enable}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            p = (i < 5) ? src_tab[i % 5] : rnd() % 8'hD1;
            wr(ADDR_DISP_SRC, p);
            v = rnd() % 8'h31;
            pix(v[5:0], (p == 8'h00) ? 8'h00 : rom_at(p, v[5:0]));
            chk(disp.source, p);
            chk({7'h00, disp.rom_timed}, {7'h00, p > 8'h95});
        end
        for (int f = 0; f < 4; f++) begin
            wr(ADDR_FADE, f[7:0]);
            // The display view lags the fade state by one cycle
            tick();
            chk({6'h00, disp.fade}, f[7:0]);
            chk({7'h00, disp.level == 8'hFF}, {7'h00, f == 0});
        end
        wr(ADDR_FADE, 8'h01);
        tick(600);
        chk(disp.level, 8'hFF);
        wr(ADDR_FADE, 8'h00);
        wr(ADDR_MTX_EN, 8'h00);
        chk({7'h00, disp.enable}, 8'h00);
        pix(6'h03, 8'h00);
        ram_clear_active = 1'b1;
        tick(2);
        rd(ADDR_STATUS, 8'h08);
        host_wr(6'h05, 8'h11);
        chk({7'h00, seen_ref}, 8'h01);
        ram_clear_active = 1'b0;
        tick(2);
        for (int i = 0; i < 2; i++) begin
            p = rnd() % 8'hD1;
            wr(ADDR_COPY_SRC, p);
            if (i == 1) wr(ADDR_MTX_EN, 8'h01);
            wr(ADDR_DISP_SRC, (i == 1) ? SRC_RAM2 : SRC_RAM1);
            wr(ADDR_COPY_CTRL, {6'h00, i[0], 1'b1});
            base = cyc - 1;
            rd(ADDR_COPY_CTRL, 8'h01);
            rd(ADDR_COPY_SRC, 8'h00);
            rd(ADDR_STATUS, 8'h08);
            seen_rep = 1'b0;
            seen_scl = 1'b0;
            wr(ADDR_DISP_SRC, 8'h05);
            wr(ADDR_REPEAT, 8'h01);
            wr(ADDR_SCROLL, 8'h01);
            wr(ADDR_COPY_SRC, ~p);
            chk({6'h00, seen_rep, seen_scl}, 8'h00);
            host_wr(6'h02, 8'h77);
            chk({7'h00, seen_ref}, 8'h01);
            chk({7'h00, disp.enable}, {7'h00, i[0]});
            while (cyc < base + 50 + i) tick();
            rd(ADDR_COPY_CTRL, (i == 1) ? 8'h02 : 8'h01);
            rd(ADDR_DISP_SRC, (i == 1) ? SRC_RAM2 : SRC_RAM1);
            rd(ADDR_COPY_SRC, p);
            wr(ADDR_MTX_EN, 8'h01);
            for (int k = 0; k < 49; k++)
                pix(k[5:0], rom_at(p, k[5:0]));
            chk({6'h00, disp.use_ram, disp.ram_sel}, {6'h00, 1'b1, i[0]});
        end
        wr(ADDR_DISP_SRC, SRC_RAM1);
        v = rnd();
        host_wr(6'h03, v);
        chk({7'h00, seen_ref}, 8'h00);
        pix(6'h03, v);
        seen_rep = 1'b0;
        seen_scl = 1'b0;
        wr(ADDR_REPEAT, 8'h01);
        wr(ADDR_SCROLL, 8'h00);
        chk({6'h00, seen_rep, seen_scl}, 8'h03);
        chk(seq_wdata, 8'h00);
        complete_run();
    end
endmodule
